/* rtl/dtsr_pkg.sv */
package dtsr_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 50;

  // Detect-time windows in microseconds
  localparam int PRESENT_MIN_US = 3000;
  localparam int PRESENT_MAX_US = 20000;
  localparam int ABSENT_MIN_US = 500;
  localparam int ABSENT_MAX_US = 20000;

  // Least times round up, longest times round down
  localparam int PRESENT_MIN_CYC = (PRESENT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESENT_MAX_CYC = (PRESENT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int ABSENT_MIN_CYC = (ABSENT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABSENT_MAX_CYC = (ABSENT_MAX_US * 1000) / CLK_PERIOD_NS;

  // Widths and reset values
  localparam int CODE_W = 4;
  localparam int TONE_W = 4;
  localparam int CNT_W = 19;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [1:0] BIT_CNT_RST = 2'h0;

  typedef enum logic [1:0] {
    DTSR_IDLE,
    DTSR_QUAL_ON,
    DTSR_PRESENT,
    DTSR_QUAL_OFF
  } dtsr_state_t;

endpackage

/* rtl/dtsr_code_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dtsr_code_if;
  logic [3:0] code;
  logic shift_rise;
  modport src (output code, output shift_rise);
  modport dst (input code, input shift_rise);
endinterface
`default_nettype wire

/* rtl/dtsr_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module dtsr_shifter (
  input wire logic sys_clk,
  input wire logic reset_n,
  dtsr_code_if.dst code_in,
  output logic serial_out
);

  logic [3:0] shreg_ff;
  logic [1:0] bit_cnt_ff;
  logic [3:0] cap_ff;
  logic [3:0] nxt_shreg;
  wire logic idle_load;

  // Between reads the register follows the latched code, so bit 0 is ready early
  assign idle_load = (bit_cnt_ff == dtsr_pkg::BIT_CNT_RST) && !code_in.shift_rise;
  assign nxt_shreg = code_in.shift_rise ? {1'b0, shreg_ff[3:1]} :
                     idle_load ? code_in.code : shreg_ff;
  assign serial_out = shreg_ff[0];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shreg_ff <= dtsr_pkg::CODE_RST;
      bit_cnt_ff <= dtsr_pkg::BIT_CNT_RST;
    end else begin
      shreg_ff <= nxt_shreg;
      // Wraps after the fourth pulse and the register reloads on the next cycle without a pulse
      if (code_in.shift_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 2'h1;
      end
    end
  end

  // Helper copy of the word as it stood at the first pulse
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cap_ff <= dtsr_pkg::CODE_RST;
    end else if (code_in.shift_rise && bit_cnt_ff == dtsr_pkg::BIT_CNT_RST) begin
      cap_ff <= shreg_ff;
    end
  end

  property p_lsb_first_order;
    @(posedge sys_clk) disable iff (!reset_n)
    (code_in.shift_rise && bit_cnt_ff != 2'h0) |-> serial_out == cap_ff[bit_cnt_ff];
  endproperty
  a_lsb_first_order: assert property (p_lsb_first_order) else $error("serial bit out of order");

  sequence s_idle_stable;
    (bit_cnt_ff == 2'h0 && !code_in.shift_rise) ##1 (bit_cnt_ff == 2'h0);
  endsequence
  property p_loaded_before_first;
    @(posedge sys_clk) disable iff (!reset_n)
    (s_idle_stable ##0 (code_in.shift_rise && $stable(code_in.code))) |->
      shreg_ff == code_in.code;
  endproperty
  a_loaded_before_first: assert property (p_loaded_before_first) else $error("code not loaded");

  property p_no_self_shift;
    @(posedge sys_clk) disable iff (!reset_n)
    (bit_cnt_ff != 2'h0 && !code_in.shift_rise) |=> $stable(serial_out);
  endproperty
  a_no_self_shift: assert property (p_no_self_shift) else $error("output moved without pulse");

endmodule
`default_nettype wire

/* rtl/dtsr_readout.sv */
// How it works
// - The tone-present flag is high while a qualified tone pair is held and through the absent window after it ends, low otherwise.
// - The flag rises between 3 ms and 20 ms after a steady valid tone pair starts.
// - The flag falls between 0.5 ms and 20 ms after the tone pair ends.
// - The key leaves as a 4-bit code on the serial output, least significant bit first.
// - The current code sits in the output shift register before the first pulse rises.
// - Bits move only on the host's shift-clock pulses, never on their own.
// - Keys 1-9 encode as binary, 0 as 1010, star 1011, hash 1100, A-C 1101-1111, D 0000.
`timescale 1ns/1ps
`default_nettype none
module dtsr_readout #(
  parameter int PRESENT_CYC = dtsr_pkg::PRESENT_MIN_CYC,
  parameter int ABSENT_CYC = dtsr_pkg::ABSENT_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] low_group_tone,
  input wire logic [3:0] high_group_tone,
  input wire logic shift_clk_in,
  output logic tone_present_flag,
  output logic serial_code_out
);

  localparam int CW = dtsr_pkg::CNT_W;

  function automatic logic [1:0] onehot_idx(input logic [3:0] oh);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (oh[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // Row and column to key code
  function automatic logic [3:0] key_code(input logic [1:0] row, input logic [1:0] col);
    logic [3:0] code;
    code = 4'h0;
    case ({row, col})
      4'h0: code = 4'h1;
      4'h1: code = 4'h2;
      4'h2: code = 4'h3;
      4'h3: code = 4'hD;
      4'h4: code = 4'h4;
      4'h5: code = 4'h5;
      4'h6: code = 4'h6;
      4'h7: code = 4'hE;
      4'h8: code = 4'h7;
      4'h9: code = 4'h8;
      4'hA: code = 4'h9;
      4'hB: code = 4'hF;
      4'hC: code = 4'hB;
      4'hD: code = 4'hA;
      4'hE: code = 4'hC;
      default: code = 4'h0;
    endcase
    return code;
  endfunction

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
  endfunction

  // Tone lines and shift clock come from outside this clock domain
  logic [3:0] low_meta_ff, low_sync_ff, high_meta_ff, high_sync_ff;
  logic sck_meta_ff, sck_sync_ff, sck_prev_ff;
  logic [CW-1:0] cnt_ff;
  logic [3:0] cand_ff;
  logic [3:0] code_ff;
  logic flag_ff;
  dtsr_pkg::dtsr_state_t state_ff;
  wire logic valid_pair;
  wire logic [3:0] cur_code;
  wire logic cand_match;
  wire logic held_match;
  wire logic on_done;
  wire logic off_done;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      low_meta_ff <= 4'h0;
      low_sync_ff <= 4'h0;
      high_meta_ff <= 4'h0;
      high_sync_ff <= 4'h0;
      sck_meta_ff <= 1'b0;
      sck_sync_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      low_meta_ff <= low_group_tone;
      low_sync_ff <= low_meta_ff;
      high_meta_ff <= high_group_tone;
      high_sync_ff <= high_meta_ff;
      sck_meta_ff <= shift_clk_in;
      sck_sync_ff <= sck_meta_ff;
      sck_prev_ff <= sck_sync_ff;
    end
  end

  // More than one tone in a group is not a key
  assign valid_pair = $onehot(low_sync_ff) && $onehot(high_sync_ff);
  assign cur_code = key_code(onehot_idx(low_sync_ff), onehot_idx(high_sync_ff));
  assign cand_match = valid_pair && (cur_code == cand_ff);
  assign held_match = valid_pair && (cur_code == code_ff);
  assign on_done = cnt_ff == CW'(PRESENT_CYC);
  assign off_done = cnt_ff == CW'(ABSENT_CYC);

  // Qualifier: a key must hold steady to be taken and stay gone to be dropped
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= dtsr_pkg::DTSR_IDLE;
      cnt_ff <= '0;
      cand_ff <= dtsr_pkg::CODE_RST;
      code_ff <= dtsr_pkg::CODE_RST;
      flag_ff <= 1'b0;
    end else begin
      case (state_ff)
        dtsr_pkg::DTSR_IDLE: begin
          if (valid_pair) begin
            state_ff <= dtsr_pkg::DTSR_QUAL_ON;
            cand_ff <= cur_code;
            cnt_ff <= CW'(1);
          end
        end
        dtsr_pkg::DTSR_QUAL_ON: begin
          // A different key restarts its window in place, so its count starts at its first cycle
          if (!cand_match && valid_pair) begin
            cand_ff <= cur_code;
            cnt_ff <= CW'(1);
          end else if (!cand_match) begin
            state_ff <= dtsr_pkg::DTSR_IDLE;
          end else if (on_done) begin
            state_ff <= dtsr_pkg::DTSR_PRESENT;
            code_ff <= cand_ff;
            flag_ff <= 1'b1;
          end else begin
            cnt_ff <= sat_inc(cnt_ff);
          end
        end
        dtsr_pkg::DTSR_PRESENT: begin
          if (!held_match) begin
            state_ff <= dtsr_pkg::DTSR_QUAL_OFF;
            cnt_ff <= CW'(1);
          end
        end
        dtsr_pkg::DTSR_QUAL_OFF: begin
          // A dropout shorter than the absent window is bridged
          if (held_match) begin
            state_ff <= dtsr_pkg::DTSR_PRESENT;
          end else if (off_done) begin
            state_ff <= dtsr_pkg::DTSR_IDLE;
            flag_ff <= 1'b0;
          end else begin
            cnt_ff <= sat_inc(cnt_ff);
          end
        end
        default: begin
          state_ff <= dtsr_pkg::DTSR_IDLE;
          flag_ff <= 1'b0;
        end
      endcase
    end
  end

  assign tone_present_flag = flag_ff;

  dtsr_code_if code_bus ();
  assign code_bus.code = code_ff;
  // Only host edges advance the shifter
  assign code_bus.shift_rise = sck_sync_ff && !sck_prev_ff;

  dtsr_shifter u_shifter (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .code_in(code_bus.dst),
    .serial_out(serial_code_out)
  );

  // Helper run counters for the checks below
  logic [CW-1:0] on_run_ff;
  logic [CW-1:0] off_run_ff;
  logic [3:0] prev_code_ff;
  logic prev_valid_ff;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      on_run_ff <= '0;
      off_run_ff <= '0;
      prev_code_ff <= 4'h0;
      prev_valid_ff <= 1'b0;
    end else begin
      prev_code_ff <= cur_code;
      prev_valid_ff <= valid_pair;
      // A new key qualifies only after the flag falls, so its run starts there
      if (!valid_pair || flag_ff) begin
        on_run_ff <= '0;
      end else if (prev_valid_ff && cur_code == prev_code_ff) begin
        on_run_ff <= sat_inc(on_run_ff);
      end else begin
        on_run_ff <= CW'(1);
      end
      off_run_ff <= (flag_ff && !held_match) ? sat_inc(off_run_ff) : '0;
    end
  end

  property p_flag_rise_late;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(tone_present_flag) |-> on_run_ff == CW'(PRESENT_CYC + 1);
  endproperty
  a_flag_rise_late: assert property (p_flag_rise_late) else $error("flag rose early");

  property p_flag_rise_bound;
    @(posedge sys_clk) disable iff (!reset_n)
    !(!tone_present_flag && on_run_ff > CW'(PRESENT_CYC + 2));
  endproperty
  a_flag_rise_bound: assert property (p_flag_rise_bound) else $error("flag rose late");

  property p_flag_fall_time;
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(tone_present_flag) |-> off_run_ff == CW'(ABSENT_CYC + 1);
  endproperty
  a_flag_fall_time: assert property (p_flag_fall_time) else $error("flag fell off time");

  property p_flag_fall_bound;
    @(posedge sys_clk) disable iff (!reset_n)
    !(tone_present_flag && off_run_ff > CW'(ABSENT_CYC + 1));
  endproperty
  a_flag_fall_bound: assert property (p_flag_fall_bound) else $error("flag held too long");

  property p_flag_means_tone;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(tone_present_flag) |-> $past(valid_pair) && code_ff == $past(cur_code);
  endproperty
  a_flag_means_tone: assert property (p_flag_means_tone) else $error("flag without tone");

  property p_key_d_code;
    @(posedge sys_clk) disable iff (!reset_n)
    (low_sync_ff == 4'h8 && high_sync_ff == 4'h8) |-> cur_code == 4'h0;
  endproperty
  a_key_d_code: assert property (p_key_d_code) else $error("key D miscoded");

  property p_key_zero_code;
    @(posedge sys_clk) disable iff (!reset_n)
    (low_sync_ff == 4'h8 && high_sync_ff == 4'h2) |-> cur_code == 4'hA;
  endproperty
  a_key_zero_code: assert property (p_key_zero_code) else $error("key 0 miscoded");

endmodule
`default_nettype wire

/* verification/dtsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtsr_host_model (
  output logic shift_clk,
  input wire logic serial_in
);
  // Shift clock stands low between reads
  initial shift_clk = 1'b0;

  // 400 ns pulse period gives a 2.5 MHz shift rate
  // Called on a falling system-clock edge; 200 ns steps keep every change on one
  task automatic read_code(output logic [3:0] v);
    for (int i = 0; i < 4; i++) begin
      v[i] = serial_in;
      shift_clk = 1'b1;
      #200;
      shift_clk = 1'b0;
      #200;
    end
  endtask
endmodule
`default_nettype wire

/* verification/dtsr_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dtsr_readout_tb;
  localparam int P = 20;
  localparam int A = 8;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] low_group_tone = 4'h0;
  logic [3:0] high_group_tone = 4'h0;
  wire logic shift_clk;
  wire logic tone_present_flag;
  wire logic serial_code_out;
  int fails = 0;
  int tests_run = 0;

  dtsr_readout #(.PRESENT_CYC(P), .ABSENT_CYC(A)) dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .low_group_tone(low_group_tone),
    .high_group_tone(high_group_tone),
    .shift_clk_in(shift_clk),
    .tone_present_flag(tone_present_flag),
    .serial_code_out(serial_code_out)
  );

  dtsr_host_model host (
    .shift_clk(shift_clk),
    .serial_in(serial_code_out)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_range(input string name, input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      fails++;
      $display("wrong value %s expected %0d to %0d seen %0d", name, lo, hi, n);
    end
  endtask

  task automatic wait_flag(input logic lvl, output int n);
    n = 0;
    while (tone_present_flag !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > 2000) begin
        fails++;
        $display("wrong value flag wait expected %b seen timeout", lvl);
        results();
      end
    end
  endtask

  function automatic logic [3:0] exp_code(input int r, input int c);
    if (r < 3 && c < 3) return 4'(r * 3 + c + 1);
    if (c == 3) return (r == 3) ? 4'h0 : 4'(13 + r);
    return (c == 0) ? 4'hB : ((c == 1) ? 4'hA : 4'hC);
  endfunction

  task automatic set_key(input int r, input int c);
    low_group_tone = 4'h1 << r;
    high_group_tone = 4'h1 << c;
  endtask

  task automatic t_reset();
    chk("flag after reset", 4'h0, {3'h0, tone_present_flag});
    chk("serial after reset", 4'h0, {3'h0, serial_code_out});
  endtask

  // Every key: timing of both flag edges and the code read back
  task automatic t_all_keys();
    int n;
    logic [3:0] v;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        set_key(r, c);
        wait_flag(1'b1, n);
        chk_range("rise cycles", n, P, P + 6);
        repeat (4) @(negedge sys_clk);
        host.read_code(v);
        chk("key code", exp_code(r, c), v);
        @(negedge sys_clk);
        set_key(8, 8);
        wait_flag(1'b0, n);
        chk_range("fall cycles", n, A, A + 6);
      end
    end
  endtask

  // Two tones in one group is no key
  task automatic t_invalid();
    logic seen = 1'b0;
    for (int k = 0; k < 2; k++) begin
      low_group_tone = (k == 0) ? 4'h3 : 4'h1;
      high_group_tone = (k == 0) ? 4'h1 : 4'hC;
      repeat (4 * P) begin
        @(negedge sys_clk);
        seen = seen | (tone_present_flag !== 1'b0);
      end
    end
    chk("flag on bad pair", 4'h0, {3'h0, seen});
    set_key(8, 8);
    repeat (A + 6) @(negedge sys_clk);
  endtask

  // Short dropout bridged; output idle without pulses; second read reloads
  task automatic t_bridge_idle();
    int n;
    logic drop = 1'b0;
    logic moved = 1'b0;
    logic [3:0] v;
    set_key(1, 1);
    wait_flag(1'b1, n);
    repeat (4) @(negedge sys_clk);
    set_key(8, 8);
    repeat (4) @(negedge sys_clk);
    set_key(1, 1);
    repeat (60) begin
      @(negedge sys_clk);
      drop = drop | (tone_present_flag !== 1'b1);
      moved = moved | (serial_code_out !== 1'b1);
    end
    chk("flag over dropout", 4'h0, {3'h0, drop});
    chk("serial moved alone", 4'h0, {3'h0, moved});
    host.read_code(v);
    chk("first read", 4'h5, v);
    host.read_code(v);
    chk("repeat read", 4'h5, v);
    @(negedge sys_clk);
    set_key(8, 8);
    wait_flag(1'b0, n);
  endtask

  // Key change while qualifying restarts; change while present waits for the fall
  task automatic t_key_change();
    int n;
    logic [3:0] v;
    set_key(0, 0);
    repeat (P / 2) @(negedge sys_clk);
    set_key(2, 2);
    wait_flag(1'b1, n);
    chk_range("restart rise cycles", n, P, P + 6);
    repeat (4) @(negedge sys_clk);
    host.read_code(v);
    chk("restarted code", 4'h9, v);
    set_key(3, 3);
    wait_flag(1'b0, n);
    chk_range("change fall cycles", n, A, A + 6);
    wait_flag(1'b1, n);
    chk_range("new key rise cycles", n, P, P + 6);
    repeat (4) @(negedge sys_clk);
    host.read_code(v);
    chk("new key code", 4'h0, v);
    set_key(8, 8);
    wait_flag(1'b0, n);
  endtask

  initial begin
    repeat (12) @(negedge sys_clk);
    t_reset();
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_all_keys();
    t_invalid();
    t_bridge_idle();
    t_key_change();
    results();
  end
endmodule
`default_nettype wire
